// [shared/pbd_regs.vh]
// Constants for the partial stream delivery engine
`ifndef PBD_REGS_VH
`define PBD_REGS_VH

// Stream command words
`define PBD_DESYNC_WORD    32'h0000000D
`define PBD_NOOP_WORD      32'h20000000
`define PBD_SYNC_WORD      32'hAA995566
`define PBD_CRC_CMD_WORD   32'h30000001
`define PBD_FAR_CMD_WORD   32'h30002001
`define PBD_FDRI_CMD_WORD  32'h30004000
`define PBD_BLANK_CMD_WORD 32'h3000C001
// Header word field: bit 31..29 type, 28..27 opcode, 10..0 count
`define PBD_HDR_TYPE_HI    31
`define PBD_HDR_TYPE_LO    29
`define PBD_HDR_CNT_HI     10
`define PBD_HDR_CNT_LO     0
// Control word positions
`define PBD_CTRL_PORT_SEL  27
`define PBD_CTRL_PMODE     28
// Reset values
`define PBD_PORT_SEL_RST   1'b1
`define PBD_DONE_RST       1'b1
// Blanking hold time
`define PBD_BLANK_NS       200
`define PBD_CLK_MHZ        20

`endif

// [verilog/pbd_fifo.v]
// Word FIFO between the selected config port and the engine
`timescale 1ns/1ps
`default_nettype none
module pbd_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             rstn,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output reg  [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire             empty
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW:0]      wp_r;
	reg [AW:0]      rp_r;
	reg [AW:0]      cnt_r;
	reg             ov_r;
	wire            wr_en;
	wire            rd_en;

	// Full from the word count, empty from the count and the output register
	assign in_ready  = (cnt_r != DEPTH[AW:0]);
	assign wr_en     = in_valid && in_ready;
	assign out_valid = ov_r;
	assign rd_en     = (cnt_r != {(AW+1){1'b0}}) && (!ov_r || out_ready);
	assign empty     = !ov_r && (cnt_r == {(AW+1){1'b0}});

	// Storage write
	always @(posedge clk) begin
		if (wr_en)
			mem_r[wp_r[AW-1:0]] <= in_data;
	end

	// Pointers, count and registered read data
	always @(posedge clk) begin
		if (!rstn) begin
			wp_r     <= {(AW+1){1'b0}};
			rp_r     <= {(AW+1){1'b0}};
			cnt_r    <= {(AW+1){1'b0}};
			ov_r     <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end else begin
			if (wr_en)
				wp_r <= wp_r + 1'b1;
			if (rd_en) begin
				rp_r     <= rp_r + 1'b1;
				out_data <= mem_r[rp_r[AW-1:0]];
				ov_r     <= 1'b1;
			end else if (out_ready) begin
				ov_r <= 1'b0;
			end
			cnt_r <= cnt_r + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
		end
	end
endmodule // pbd_fifo
`default_nettype wire

// [verilog/pbd_engine.v]
// Partial stream delivery engine: port select, parser, done and region gating
`timescale 1ns/1ps
`default_nettype none
`include "pbd_regs.vh"

module pbd_engine #(
	parameter ROUT_W   = 8,
	parameter FIFO_D   = 4,
	parameter FIFO_AW  = 2,
	parameter TIE_HIGH = 8'h00
) (
	input  wire              clk,
	input  wire              rstn,
	input  wire [31:0]       ctrl_word,
	input  wire              newer_family,
	input  wire              su_port_select,
	input  wire              pins_persist,
	input  wire              reset_after_reconfig,
	input  wire              clear_needed,
	input  wire              stream_is_clear,
	input  wire              stream_is_blank,
	input  wire [31:0]       icfg_data,
	input  wire              icfg_valid,
	output wire              icfg_ready,
	input  wire [31:0]       pcfg_data,
	input  wire              pcfg_valid,
	output wire              pcfg_ready,
	input  wire [ROUT_W-1:0] rm_out,
	output reg  [ROUT_W-1:0] region_out,
	output reg               done_out,
	output reg               stream_end,
	output reg               crc_error,
	output reg               region_mask,
	output reg               region_clk_en,
	output reg               region_init,
	output reg  [31:0]       frame_addr,
	output reg  [31:0]       frame_data,
	output reg               frame_we,
	output reg               loading,
	output wire              port_is_proc
);
	localparam ST_IDLE = 3'd0;
	localparam ST_SYNC = 3'd1;
	localparam ST_CMD  = 3'd2;
	localparam ST_FAR  = 3'd3;
	localparam ST_DATA = 3'd4;
	localparam ST_CRC  = 3'd5;
	localparam ST_BLNK = 3'd6;
	localparam BLANK_CYC = (`PBD_BLANK_NS * `PBD_CLK_MHZ + 999) / 1000;

	reg  [2:0]        st_r;
	reg  [10:0]       cnt_r;
	reg  [31:0]       crc_r;
	reg  [7:0]        bcnt_r;
	reg  [ROUT_W-1:0] hold_r;
	reg               pend_clear_r;
	reg               was_blank_r;
	reg               in_clear_r;
	wire              sel_proc;
	wire              internal_config_port_ok;
	wire [31:0]       f_data;
	wire              f_valid;
	wire              f_ready;
	wire [31:0]       m_data;
	wire              m_valid;
	wire              m_ready;
	wire              f_empty;
	wire              take;
	wire              sync_take;
	wire              cmd_take;
	wire              end_take;
	wire              blank_go;
	wire              far_take;
	wire              data_take;
	wire              crc_take;
	wire              last_data;

	// Running checksum step: rotate left by one, then fold in the word
	function [31:0] crc_step;
		input [31:0] c;
		input [31:0] w;
		begin
			crc_step = {c[30:0], c[31]} ^ w;
		end
	endfunction

	// Type-1 write header aimed at the frame data register
	// The low eleven bits carry the word count and are masked off
	function is_data_hdr;
		input [31:0] w;
		begin
			is_data_hdr = ((w & 32'hFFFFF800) == `PBD_FDRI_CMD_WORD);
		end
	endfunction

	// Word count of a data header
	function [10:0] hdr_count;
		input [31:0] w;
		begin
			hdr_count = w[`PBD_HDR_CNT_HI:`PBD_HDR_CNT_LO];
		end
	endfunction

	// Port choice: bit 27 or security-unit field, internal port gated
	assign sel_proc = newer_family ? su_port_select
		: ctrl_word[`PBD_CTRL_PORT_SEL];
	assign internal_config_port_ok  = !pins_persist;
	assign port_is_proc = sel_proc;
	assign f_data   = sel_proc ? pcfg_data : icfg_data;
	assign f_valid  = sel_proc ? pcfg_valid : (icfg_valid && internal_config_port_ok);
	assign pcfg_ready = sel_proc && f_ready;
	assign icfg_ready = !sel_proc && internal_config_port_ok && f_ready;

	pbd_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_D),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_data   (f_data),
		.in_valid  (f_valid),
		.in_ready  (f_ready),
		.out_data  (m_data),
		.out_valid (m_valid),
		.out_ready (m_ready),
		.empty     (f_empty)
	);

	// Engine stalls while a blanking event holds the outputs
	assign m_ready = (st_r != ST_BLNK);
	assign take    = m_valid && m_ready;

	// Decoded strobes for sync, command, end, blanking, address, data and checksum words
	// The parser still decodes the noop, address command, checksum command and data header itself
	assign sync_take = take && (st_r == ST_IDLE)
		&& (m_data == `PBD_SYNC_WORD);
	assign cmd_take  = take && (st_r == ST_CMD);
	assign end_take  = cmd_take && (m_data == `PBD_DESYNC_WORD);
	assign blank_go  = cmd_take && (m_data == `PBD_BLANK_CMD_WORD);
	assign far_take  = take && (st_r == ST_FAR);
	assign data_take = take && (st_r == ST_DATA);
	assign crc_take  = take && (st_r == ST_CRC);
	assign last_data = (cnt_r <= 11'h001);

	// Parser state, data word count and blanking hold count
	always @(posedge clk) begin
		if (!rstn) begin
			st_r   <= ST_IDLE;
			cnt_r  <= 11'h000;
			bcnt_r <= 8'h00;
		end else begin
			case (st_r)
			ST_IDLE: begin
				// Words before the sync word are dropped
				if (sync_take)
					st_r <= ST_CMD;
			end
			ST_SYNC: begin
				st_r <= ST_CMD;
			end
			ST_CMD: begin
				if (end_take) begin
					// Noop padding already retired all writes
					st_r <= ST_IDLE;
				end else if (cmd_take) begin
					if (m_data == `PBD_NOOP_WORD) begin
						st_r <= ST_CMD;
					end else if (m_data == `PBD_FAR_CMD_WORD) begin
						st_r <= ST_FAR;
					end else if (m_data == `PBD_CRC_CMD_WORD) begin
						st_r <= ST_CRC;
					end else if (blank_go) begin
						st_r   <= ST_BLNK;
						bcnt_r <= BLANK_CYC[7:0];
					end else if (is_data_hdr(m_data)) begin
						st_r  <= ST_DATA;
						cnt_r <= hdr_count(m_data);
					end
				end
			end
			ST_FAR: begin
				if (far_take)
					st_r <= ST_CMD;
			end
			ST_DATA: begin
				if (data_take) begin
					if (last_data)
						st_r <= ST_CMD;
					cnt_r <= cnt_r - 11'h001;
				end
			end
			ST_CRC: begin
				if (crc_take)
					st_r <= ST_CMD;
			end
			ST_BLNK: begin
				// Fixed hold, then back to commands
				if (bcnt_r <= 8'h01)
					st_r <= ST_CMD;
				bcnt_r <= bcnt_r - 8'h01;
			end
			default: begin
				st_r <= ST_IDLE;
			end
			endcase
		end
	end

	// Loading flag and stream kind, latched at the sync word
	always @(posedge clk) begin
		if (!rstn) begin
			loading     <= 1'b0;
			in_clear_r  <= 1'b0;
			was_blank_r <= 1'b0;
		end else if (sync_take) begin
			loading    <= 1'b1;
			in_clear_r <= stream_is_clear;
			// A clearing stream keeps the tie-off of the module before it
			if (!stream_is_clear)
				was_blank_r <= stream_is_blank;
		end else if (end_take) begin
			loading <= 1'b0;
		end
	end

	// Running checksum over address and data words, checked in-stream
	always @(posedge clk) begin
		if (!rstn) begin
			crc_r     <= 32'h00000000;
			crc_error <= 1'b0;
		end else if (sync_take) begin
			crc_r     <= 32'h00000000;
			crc_error <= 1'b0;
		end else if (far_take || data_take) begin
			crc_r <= crc_step(crc_r, m_data);
		end else if (crc_take && (m_data != crc_r)) begin
			crc_error <= 1'b1;
		end
	end

	// Done pin: low from the sync word, high on an intact partial end
	// Only meaningful with reset-after-reconfig; otherwise it stays put
	always @(posedge clk) begin
		if (!rstn) begin
			done_out <= `PBD_DONE_RST;
		end else if (reset_after_reconfig) begin
			if (sync_take)
				done_out <= 1'b0;
			else if (end_take && !in_clear_r)
				done_out <= !crc_error;
			// A clearing stream end leaves done low
		end
	end

	// Region mask and clock gate at the end of each stream, init pulse only at a partial stream end
	always @(posedge clk) begin
		if (!rstn) begin
			stream_end    <= 1'b0;
			region_mask   <= 1'b0;
			region_clk_en <= 1'b1;
			region_init   <= 1'b0;
			pend_clear_r  <= 1'b0;
		end else begin
			stream_end  <= end_take;
			region_init <= 1'b0;
			if (end_take && in_clear_r) begin
				region_mask   <= 1'b1;
				region_clk_en <= 1'b0;
				pend_clear_r  <= 1'b1;
			end else if (end_take) begin
				// No startup: only the region is released
				region_mask   <= 1'b0;
				region_clk_en <= 1'b1;
				// Init only after a clearing stream, or if none is needed
				region_init   <= pend_clear_r || !clear_needed;
				pend_clear_r  <= 1'b0;
			end
		end
	end

	// Frame address and data toward the configuration memory
	// Write strobe stands one cycle per data word
	always @(posedge clk) begin
		if (!rstn) begin
			frame_addr <= 32'h00000000;
			frame_data <= 32'h00000000;
			frame_we   <= 1'b0;
		end else begin
			frame_we <= data_take;
			if (far_take)
				frame_addr <= m_data;
			if (data_take)
				frame_data <= m_data;
		end
	end

	// Output value frozen when a blanking event is accepted
	always @(posedge clk) begin
		if (!rstn)
			hold_r <= {ROUT_W{1'b0}};
		else if (blank_go)
			hold_r <= region_out;
	end

	// Region outputs: held, tied off, or live; static logic never touched
	// The edge that accepts a blanking word already holds the old value,
	// so no live value slips out between the command and the hold
	always @(posedge clk) begin
		if (!rstn) begin
			region_out <= {ROUT_W{1'b0}};
		end else if (blank_go) begin
			region_out <= region_out;
		end else if (st_r == ST_BLNK) begin
			region_out <= hold_r;
		end else if (was_blank_r && !loading) begin
			region_out <= TIE_HIGH[ROUT_W-1:0];
		end else if (!region_clk_en) begin
			region_out <= region_out;
		end else begin
			region_out <= rm_out;
		end
	end
endmodule // pbd_engine
`default_nettype wire

// [sim/pbd_engine_checker.sv]
// Port-level assertions for the partial stream engine
`timescale 1ns/1ps
`default_nettype none
module pbd_engine_checker (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [31:0] ctrl_word,
	input wire logic        newer_family,
	input wire logic        su_port_select,
	input wire logic        pins_persist,
	input wire logic        icfg_ready,
	input wire logic        pcfg_ready,
	input wire logic        port_is_proc,
	input wire logic        done_out,
	input wire logic        stream_end,
	input wire logic        crc_error,
	input wire logic        frame_we,
	input wire logic        loading
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// End of delivery is a single-cycle pulse
	sequence s_end_pulse;
		stream_end ##1 !stream_end;
	endsequence
	// Port choice and refusal of the idle port
	a_port_by_bit: assert property (
		!newer_family |-> port_is_proc == ctrl_word[27])
		else $error("port select ignores control bit");
	a_port_by_su: assert property (
		newer_family |-> port_is_proc == su_port_select)
		else $error("port select ignores security unit field");
	a_persist_off: assert property (pins_persist |-> !icfg_ready)
		else $error("internal port open while pins persist");
	a_int_idle: assert property (port_is_proc |-> !icfg_ready)
		else $error("internal port ready while processor port chosen");
	a_proc_idle: assert property (!port_is_proc |-> !pcfg_ready)
		else $error("processor port ready while internal port chosen");
	// Done only rises on a finished, intact stream
	a_done_rise: assert property (
		$rose(done_out) |-> stream_end || $past(stream_end))
		else $error("done rose without end of stream");
	a_crc_done: assert property (crc_error |-> !$rose(done_out))
		else $error("done rose despite checksum error");
	a_end_pulse: assert property (stream_end |-> s_end_pulse)
		else $error("end of stream not a single pulse");
	a_we_load: assert property (frame_we |-> loading)
		else $error("frame write outside loading");
endmodule // pbd_engine_checker
bind pbd_engine pbd_engine_checker u_pbd_engine_checker (.clk(clk),
	.rstn(rstn), .ctrl_word(ctrl_word), .newer_family(newer_family),
	.su_port_select(su_port_select), .pins_persist(pins_persist),
	.icfg_ready(icfg_ready), .pcfg_ready(pcfg_ready),
	.port_is_proc(port_is_proc), .done_out(done_out),
	.stream_end(stream_end), .crc_error(crc_error),
	.frame_we(frame_we), .loading(loading));
`default_nettype wire

// [sim/pbd_ctrl_model.sv]
// Controller model feeding one configuration port
`timescale 1ns/1ps
`default_nettype none
module pbd_ctrl_model (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic        ready,
	output var  logic [31:0] data,
	output var  logic        valid
);
	logic [31:0] q[$];
	logic        took = 1'b0;
	initial begin
		data = 32'h0;
		valid = 1'b0;
	end
	// Transfer where valid and ready meet at the edge
	always @(posedge clk) took <= valid && ready;
	// Words leave in queue order, held until taken
	always @(negedge clk) begin
		if (took)
			void'(q.pop_front());
		if (took || !valid) begin
			if (q.size() != 0 && !(slow && $urandom_range(1))) begin
				valid = 1'b1;
				data = q[0];
			end else begin
				valid = 1'b0;
				data = ~data; // Idle bus inverts each cycle, so the last word returns every other cycle
			end
		end
	end
endmodule // pbd_ctrl_model
`default_nettype wire

// [sim/pbd_engine_tb.sv]
// Self-checking bench for the partial stream engine
`timescale 1ns/1ps
`default_nettype none
`include "pbd_regs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pbd_engine_tb;
	localparam   TIE = 8'hA5;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [31:0] ctrl_word = 32'h18000000;
	logic        newer = 1'b0, su_sel = 1'b1, persist = 1'b0, rar = 1'b1;
	logic        clr_need = 1'b0, is_clr = 1'b0, is_blank = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  rm_out = 8'h00;
	wire  [31:0] idata, pdata, faddr, fdata;
	wire  [7:0]  rout;
	wire         ivalid, iready, pvalid, pready, proc, done, s_end;
	wire         crc_err, mask, clk_en, init, we, load;
	logic [31:0] exp_q[$];
	logic [31:0] exp_addr, exp_w;
	int          fails = 0, num_checks = 0, n_end = 0, n_init = 0;
	int          cyc = 0, e;
	pbd_ctrl_model u_pbd_ctrl_model_i (.clk(clk), .slow(slow),
		.ready(iready), .data(idata), .valid(ivalid));
	pbd_ctrl_model u_pbd_ctrl_model_p (.clk(clk), .slow(slow),
		.ready(pready), .data(pdata), .valid(pvalid));
	pbd_engine #(.TIE_HIGH(TIE)) u_pbd_engine (.clk(clk), .rstn(rstn),
		.ctrl_word(ctrl_word), .newer_family(newer),
		.su_port_select(su_sel), .pins_persist(persist),
		.reset_after_reconfig(rar), .clear_needed(clr_need),
		.stream_is_clear(is_clr), .stream_is_blank(is_blank),
		.icfg_data(idata), .icfg_valid(ivalid), .icfg_ready(iready),
		.pcfg_data(pdata), .pcfg_valid(pvalid), .pcfg_ready(pready),
		.rm_out(rm_out), .region_out(rout), .done_out(done),
		.stream_end(s_end), .crc_error(crc_err), .region_mask(mask),
		.region_clk_en(clk_en), .region_init(init), .frame_addr(faddr),
		.frame_data(fdata), .frame_we(we), .loading(load),
		.port_is_proc(proc));
	always #25 clk = ~clk;
	// Frame writes, pulse counts and hang limit, sampled mid-cycle
	always @(negedge clk) begin
		cyc++;
		if (s_end) n_end++;
		if (init) n_init++;
		if (we) begin
			exp_w = exp_q.pop_front();
			`CHK(fdata, exp_w)
			`CHK(faddr, exp_addr)
			if (rar) `CHK(done, 1'b0)
		end
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Checksum step: rotate left by one, xor in the word
	function automatic logic [31:0] crc_next(input logic [31:0] c,
		input logic [31:0] w);
		return {c[30:0], c[31]} ^ w;
	endfunction
	task automatic push(input logic [31:0] w);
		if (proc) u_pbd_ctrl_model_p.q.push_back(w);
		else u_pbd_ctrl_model_i.q.push_back(w);
	endtask
	// One whole stream with random frame data
	task automatic stream(input logic clr, input logic blank, input logic bad);
		int n, e0;
		logic [31:0] c;
		n = $urandom_range(6, 1);
		e0 = n_end;
		exp_addr = $urandom;
		c = crc_next(32'h0, exp_addr);
		is_clr = clr;
		is_blank = blank;
		slow = 1'($urandom_range(1));
		push(`PBD_SYNC_WORD);
		push(`PBD_FAR_CMD_WORD);
		push(exp_addr);
		push(`PBD_FDRI_CMD_WORD | n);
		repeat (n) begin
			exp_q.push_back($urandom);
			push(exp_q[$]);
			c = crc_next(c, exp_q[$]);
		end
		push(`PBD_CRC_CMD_WORD);
		push(bad ? ~c : c);
		push(`PBD_BLANK_CMD_WORD);
		repeat (2) push(`PBD_NOOP_WORD);
		push(`PBD_DESYNC_WORD);
		for (int i = 0; i < 300 && n_end == e0; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		`CHK(n_end, e0 + 1)
		`CHK(exp_q.size(), 0)
		`CHK(u_pbd_ctrl_model_i.q.size() + u_pbd_ctrl_model_p.q.size(), 0)
	endtask
	initial begin
		void'($urandom(32'hBA33));
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		`CHK(done, 1'b1)
		`CHK(clk_en, 1'b1)
		`CHK(proc, 1'b1)
		`CHK(load, 1'b0)
		ctrl_word[27] = 1'b0; // Bit 28 stays set
		@(negedge clk);
		`CHK(proc, 1'b0)
		repeat (3) begin
			rm_out = 8'($urandom);
			stream(0, 0, 0);
			`CHK(done, 1'b1)
			`CHK(crc_err, 1'b0)
			`CHK(rout, rm_out)
		end
		$display("test plain streams done");
		// Clearing stream then partial stream
		clr_need = 1'b1;
		stream(1, 0, 0);
		`CHK(done, 1'b0)
		`CHK(mask, 1'b1)
		`CHK(clk_en, 1'b0)
		e = n_init;
		stream(0, 0, 0);
		`CHK(done, 1'b1)
		`CHK(n_init, e + 1)
		clr_need = 1'b0;
		$display("test clearing done");
		stream(0, 0, 1);
		`CHK(crc_err, 1'b1)
		`CHK(done, 1'b0)
		$display("test bad checksum done");
		rm_out = 8'($urandom);
		stream(0, 1, 0);
		`CHK(rout, TIE)
		`CHK(done, 1'b1)
		$display("test blanking done");
		// Port choice by control bit and security unit field
		for (int k = 0; k < 3; k++) begin
			ctrl_word[27] = (k != 1); // Both ports idle here
			newer = (k != 0);
			su_sel = (k == 1);
			@(negedge clk);
			`CHK(proc, k < 2)
			stream(0, 0, 0);
			`CHK(done, 1'b1)
		end
		persist = 1'b1;
		@(negedge clk);
		`CHK(iready, 1'b0)
		`CHK(pready, 1'b0)
		persist = 1'b0;
		rar = 1'b0;
		stream(0, 0, 0);
		`CHK(done, 1'b1)
		$display("test ports done");
		complete_run();
	end
endmodule // pbd_engine_tb
`default_nettype wire
